// ### logic/smrb_consts.vh
// constants for the static memory read bus interface
`ifndef SMRB_CONSTS_VH
`define SMRB_CONSTS_VH
// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define SMRB_NUM_CS        6
`define SMRB_ADDR_W        26
`define SMRB_TIME_W        9
// ---------------------------------------------------------------
// mode field encodings
// ---------------------------------------------------------------
`define SMRB_DBW_8         2'h0
`define SMRB_DBW_16        2'h1
`define SMRB_DBW_32        2'h2
`define SMRB_BAT_SELECT    1'h0
`define SMRB_BAT_WRITE     1'h1
`define SMRB_RDMODE_CS     1'h0
`define SMRB_RDMODE_RD     1'h1
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SMRB_BOOT_CS       3'h0
`endif

// ### logic/smrb_strobe_gen.v
// one active-low strobe built from setup and pulse counts
`default_nettype none
module smrb_strobe_gen (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       busy,
  input  wire [8:0] count,
  input  wire [8:0] setup,
  input  wire [8:0] pulse,
  output wire       next_low,
  output wire       rise_edge
);
  // ---------------------------------------------------------------
  // strobe level for the coming cycle
  // ---------------------------------------------------------------
  // hold = total - setup - pulse falls out of the window test
  wire [9:0] pulse_end;
  assign pulse_end = {1'b0, setup} + {1'b0, pulse};
  assign next_low  = busy && ({1'b0, count} >= {1'b0, setup}) && ({1'b0, count} < pulse_end);
  // last low cycle flagged and registered, so the capture falls on the edge
  // that ends the pulse even when that edge already belongs to idle
  reg pulse_last;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_last <= 1'b0;
    end else begin
      pulse_last <= busy && ({1'b0, count} == pulse_end - 10'h001);
    end
  end
  assign rise_edge = pulse_last;
endmodule // smrb_strobe_gen
`default_nettype wire

// ### logic/smrb_lane_map.v
// maps width, access type and low address to shared control pins
`include "smrb_consts.vh"
`default_nettype none
module smrb_lane_map (
  input  wire [1:0] bus_width_field,
  input  wire       access_type_field,
  input  wire [1:0] addr_lo,
  input  wire [3:0] lane_en,
  input  wire       wr_low,
  output reg  [3:0] pin_lvl
);
  // ---------------------------------------------------------------
  // shared pin function table
  // ---------------------------------------------------------------
  // pin0: a0 / byte_sel0_n / byte_wr0_n, pin2: a1 / byte_sel2_n / byte_wr2_n
  always @* begin
    pin_lvl = 4'hF;
    case (bus_width_field)
      `SMRB_DBW_8: begin
        pin_lvl = {1'b1, addr_lo[1], 1'b1, addr_lo[0]};
      end
      `SMRB_DBW_16: begin
        if (access_type_field == `SMRB_BAT_WRITE) begin
          pin_lvl = {1'b1, addr_lo[1], ~(wr_low & lane_en[1]), ~(wr_low & lane_en[0])};
        end else begin
          pin_lvl = {1'b1, addr_lo[1], ~lane_en[1], ~lane_en[0]};
        end
      end
      default: begin
        if (access_type_field == `SMRB_BAT_WRITE) begin
          pin_lvl = ~({4{wr_low}} & lane_en);
        end else begin
          pin_lvl = ~lane_en;
        end
      end
    endcase
  end
endmodule // smrb_lane_map
`default_nettype wire

// ### logic/smrb_read_ctrl.v
// static memory read controller: address drive and read strobes
`include "smrb_consts.vh"
`default_nettype none
// Contract
// - drive 26 address lines, 64 Mbyte regions
// - small devices alias across whole region
// - significant address bits depend on width
// - per chip select bus width field
// - access type field picks write or select
// - byte write: per lane strobes, one read
// - 32-bit byte write lanes zero to three
// - no boot on byte write chip select
// - byte select lines plus read, write enable
// - select lines map to byte lanes
// - shared pins follow width and type
// - low address bits unused on wide buses
// - unused strobes idle per access type
// - selects timed as address, writes as enable
// - read begins by driving the address
// - read strobe setup, pulse, hold phases
// - chip select has own read phases
// - per chip select cycle counts, total governs
// - read strobe hold derived from total
// - chip select hold derived from total
// - zero setup/hold keeps strobes asserted
// - read mode bit picks capture strobe
// - mode one captures at read strobe rise
// - mode zero captures at chip select rise
module smrb_read_ctrl (
  input  wire         clk,
  input  wire         rst_n,
  // request side
  input  wire         req_valid,
  input  wire [2:0]   req_cs,
  input  wire [25:0]  req_addr,
  input  wire [3:0]   req_lanes,
  output reg          req_ready,
  output reg          rd_done,
  output reg  [31:0]  rd_data,
  output reg          boot_fault,
  // per chip select configuration, flattened by chip select
  input  wire [11:0]  cfg_bus_width,
  input  wire [5:0]   cfg_access_type,
  input  wire [5:0]   cfg_read_mode,
  input  wire [53:0]  cfg_rd_setup,
  input  wire [53:0]  cfg_rd_pulse,
  input  wire [53:0]  cfg_cs_setup,
  input  wire [53:0]  cfg_cs_pulse,
  input  wire [53:0]  cfg_cycle_total,
  // external pins
  output reg  [25:0]  mem_addr,
  output reg  [5:0]   chip_sel_n,
  output reg          rd_strobe_n,
  output reg          wr_enable_n,
  output reg          pin0_n,
  output reg          byte_wr1_n,
  output reg          pin2_n,
  output reg          pin3_n,
  input  wire [31:0]  mem_data_in
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_READ = 1'b1;
  reg        state;
  reg [2:0]  cur_cs;
  reg [25:0] cur_addr;
  reg [3:0]  cur_lanes;
  reg [8:0]  count;
  // mode of the access in flight, for the capture edge
  reg        cur_mode;
  // per chip select fields of the active access
  reg  [1:0] width_sel;
  reg        type_sel;
  reg        mode_sel;
  reg  [8:0] rd_setup;
  reg  [8:0] rd_pulse;
  reg  [8:0] cs_setup;
  reg  [8:0] cs_pulse;
  reg  [8:0] total;
  wire [2:0] sel_cs;
  // fields come from the request at launch so the first cycle is timed right
  assign sel_cs    = (state == ST_IDLE) ? req_cs : cur_cs;
  // ---------------------------------------------------------------
  // per chip select field decode
  // ---------------------------------------------------------------
  // fixed slices: chip selects 6 and 7 read zeros, never past the buses
  always @* begin
    case (sel_cs)
      3'h0: begin
        width_sel = cfg_bus_width[1:0];
        type_sel  = cfg_access_type[0];
        mode_sel  = cfg_read_mode[0];
      end
      3'h1: begin
        width_sel = cfg_bus_width[3:2];
        type_sel  = cfg_access_type[1];
        mode_sel  = cfg_read_mode[1];
      end
      3'h2: begin
        width_sel = cfg_bus_width[5:4];
        type_sel  = cfg_access_type[2];
        mode_sel  = cfg_read_mode[2];
      end
      3'h3: begin
        width_sel = cfg_bus_width[7:6];
        type_sel  = cfg_access_type[3];
        mode_sel  = cfg_read_mode[3];
      end
      3'h4: begin
        width_sel = cfg_bus_width[9:8];
        type_sel  = cfg_access_type[4];
        mode_sel  = cfg_read_mode[4];
      end
      3'h5: begin
        width_sel = cfg_bus_width[11:10];
        type_sel  = cfg_access_type[5];
        mode_sel  = cfg_read_mode[5];
      end
      default: begin
        width_sel = `SMRB_DBW_8;
        type_sel  = `SMRB_BAT_SELECT;
        mode_sel  = `SMRB_RDMODE_CS;
      end
    endcase
  end
  // timings are whole cycles; hold is never stored, it is what the total leaves
  always @* begin
    case (sel_cs)
      3'h0: begin
        rd_setup = cfg_rd_setup[8:0];
        rd_pulse = cfg_rd_pulse[8:0];
        cs_setup = cfg_cs_setup[8:0];
        cs_pulse = cfg_cs_pulse[8:0];
        total    = cfg_cycle_total[8:0];
      end
      3'h1: begin
        rd_setup = cfg_rd_setup[17:9];
        rd_pulse = cfg_rd_pulse[17:9];
        cs_setup = cfg_cs_setup[17:9];
        cs_pulse = cfg_cs_pulse[17:9];
        total    = cfg_cycle_total[17:9];
      end
      3'h2: begin
        rd_setup = cfg_rd_setup[26:18];
        rd_pulse = cfg_rd_pulse[26:18];
        cs_setup = cfg_cs_setup[26:18];
        cs_pulse = cfg_cs_pulse[26:18];
        total    = cfg_cycle_total[26:18];
      end
      3'h3: begin
        rd_setup = cfg_rd_setup[35:27];
        rd_pulse = cfg_rd_pulse[35:27];
        cs_setup = cfg_cs_setup[35:27];
        cs_pulse = cfg_cs_pulse[35:27];
        total    = cfg_cycle_total[35:27];
      end
      3'h4: begin
        rd_setup = cfg_rd_setup[44:36];
        rd_pulse = cfg_rd_pulse[44:36];
        cs_setup = cfg_cs_setup[44:36];
        cs_pulse = cfg_cs_pulse[44:36];
        total    = cfg_cycle_total[44:36];
      end
      3'h5: begin
        rd_setup = cfg_rd_setup[53:45];
        rd_pulse = cfg_rd_pulse[53:45];
        cs_setup = cfg_cs_setup[53:45];
        cs_pulse = cfg_cs_pulse[53:45];
        total    = cfg_cycle_total[53:45];
      end
      default: begin
        rd_setup = 9'h000;
        rd_pulse = 9'h000;
        cs_setup = 9'h000;
        cs_pulse = 9'h000;
        total    = 9'h000;
      end
    endcase
  end
  // ---------------------------------------------------------------
  // launch and cycle counting
  // ---------------------------------------------------------------
  wire boot_bad;
  wire launch;
  wire [8:0] cnt_now;
  wire last;
  // byte write on the boot chip select is refused
  assign boot_bad = (req_cs == `SMRB_BOOT_CS) && (type_sel == `SMRB_BAT_WRITE)
                    && (width_sel != `SMRB_DBW_8);
  // chip selects 6 and 7 have no pins, so they are never taken
  assign launch   = req_valid && req_ready && !boot_bad && (req_cs < 3'h6);
  assign cnt_now  = (state == ST_IDLE) ? 9'h000 : count;
  assign last     = (cnt_now + 9'h001 >= total);
  wire busy;
  assign busy = launch || (state == ST_READ);
  // ---------------------------------------------------------------
  // strobe generators
  // ---------------------------------------------------------------
  wire rd_low;
  wire rd_rise;
  wire cs_low;
  wire cs_rise;
  smrb_strobe_gen u_rd_strobe (
    .clk       (clk),
    .rst_n     (rst_n),
    .busy      (busy),
    .count     (cnt_now),
    .setup     (rd_setup),
    .pulse     (rd_pulse),
    .next_low  (rd_low),
    .rise_edge (rd_rise)
  );
  smrb_strobe_gen u_cs_strobe (
    .clk       (clk),
    .rst_n     (rst_n),
    .busy      (busy),
    .count     (cnt_now),
    .setup     (cs_setup),
    .pulse     (cs_pulse),
    .next_low  (cs_low),
    .rise_edge (cs_rise)
  );
  // ---------------------------------------------------------------
  // shared pins
  // ---------------------------------------------------------------
  wire [25:0] addr_src;
  wire [3:0]  lane_src;
  wire [3:0]  pin_lvl;
  assign addr_src = (state == ST_IDLE) ? req_addr : cur_addr;
  assign lane_src = (state == ST_IDLE) ? req_lanes : cur_lanes;
  // reads never pulse write strobes, so byte writes stay high
  smrb_lane_map u_lane_map (
    .bus_width_field   (width_sel),
    .access_type_field (type_sel),
    .addr_lo           (addr_src[1:0]),
    .lane_en           (lane_src),
    .wr_low            (1'b0),
    .pin_lvl           (pin_lvl)
  );
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cur_cs    <= 3'h0;
      cur_addr  <= 26'h0000000;
      cur_lanes <= 4'h0;
      count     <= 9'h000;
      cur_mode  <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (launch) begin
            cur_cs    <= req_cs;
            cur_addr  <= req_addr;
            cur_lanes <= req_lanes;
            count     <= 9'h001;
            // mode is kept: the capture edge may land after the access went idle
            cur_mode  <= mode_sel;
            if (last) begin
              state <= ST_IDLE;
            end else begin
              state     <= ST_READ;
              req_ready <= 1'b0;
            end
          end
        end
        ST_READ: begin
          count <= count + 9'h001;
          if (last) begin
            state     <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // pin registers
  // ---------------------------------------------------------------
  // address holds after the access so zero hold keeps lines steady
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr    <= 26'h0000000;
      chip_sel_n  <= 6'h3F;
      rd_strobe_n <= 1'b1;
      wr_enable_n <= 1'b1;
      pin0_n      <= 1'b1;
      byte_wr1_n  <= 1'b1;
      pin2_n      <= 1'b1;
      pin3_n      <= 1'b1;
    end else begin
      if (busy) begin
        case (width_sel)
          `SMRB_DBW_8:  mem_addr <= addr_src;
          `SMRB_DBW_16: mem_addr <= {addr_src[25:1], 1'b0};
          default:      mem_addr <= {addr_src[25:2], 2'b00};
        endcase
        pin0_n     <= pin_lvl[0];
        byte_wr1_n <= pin_lvl[1];
        pin2_n     <= pin_lvl[2];
        pin3_n     <= pin_lvl[3];
      end
      // back-to-back reads with null setup/hold never see a high cycle
      rd_strobe_n <= ~rd_low;
      chip_sel_n  <= ~({5'h00, cs_low} << sel_cs);
      // no write path here, so the write enable idles high
      wr_enable_n <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // read data capture
  // ---------------------------------------------------------------
  // governing strobe picked by the mode latched at launch
  wire cap_edge;
  assign cap_edge = (cur_mode == `SMRB_RDMODE_RD) ? rd_rise : cs_rise;
  // capture on the edge that raises the governing strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done    <= 1'b0;
      rd_data    <= 32'h00000000;
      boot_fault <= 1'b0;
    end else begin
      rd_done    <= 1'b0;
      boot_fault <= req_valid && req_ready && boot_bad;
      if (cap_edge) begin
        rd_done <= 1'b1;
        rd_data <= mem_data_in;
      end
    end
  end
endmodule // smrb_read_ctrl
`default_nettype wire

// ### sim/smrb_read_chk_assertions.sv
// assertions on the static memory read controller ports
`default_nettype none
module smrb_read_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic [2:0]  req_cs,
  input wire logic [25:0] req_addr,
  input wire logic        req_ready,
  input wire logic        boot_fault,
  input wire logic [11:0] cfg_bus_width,
  input wire logic [5:0]  cfg_access_type,
  input wire logic [53:0] cfg_cycle_total,
  input wire logic [25:0] mem_addr,
  input wire logic [5:0]  chip_sel_n,
  input wire logic        wr_enable_n,
  input wire logic        pin0_n,
  input wire logic        pin2_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // request decode
  // ----
  // chip selects 6 and 7 index past the fields, so take masks them
  wire logic [1:0] w   = cfg_bus_width[req_cs*2 +: 2];
  wire logic [8:0] tot = cfg_cycle_total[req_cs*9 +: 9];
  wire logic       bad = req_cs == 3'h0 && cfg_access_type[0] && w != 2'h0;
  wire logic       take = req_valid && req_ready && !bad && req_cs < 3'h6;
  // ----
  // properties
  // ----
  a_wr_idle: assert property (wr_enable_n)
    else $error("write enable driven in read-only block");
  a_one_cs: assert property ($countones(~chip_sel_n) <= 1)
    else $error("more than one chip select low");
  a_busy_drop: assert property (take && tot > 9'h1 |=> !req_ready)
    else $error("ready stayed high after a take");
  a_busy_span: assert property (take && tot == 9'h8 |=> !req_ready [*7] ##1 req_ready)
    else $error("ready gap differs from cycle total");
  a_addr_out: assert property (take |=> mem_addr[25:2] == $past(req_addr[25:2]))
    else $error("address not driven from request");
  a_wide_zero: assert property (take && w == 2'h2 |=> mem_addr[1:0] == 2'h0)
    else $error("low address bits set on wide bus");
  a_half_zero: assert property (take && w == 2'h1 |=> !mem_addr[0])
    else $error("address bit zero set on half bus");
  a_a0_pin: assert property (take && w == 2'h0 |=> pin0_n == $past(req_addr[0]))
    else $error("shared pin zero not address bit zero");
  a_a1_pin: assert property (take && (w == 2'h0 || w == 2'h1) |=> pin2_n == $past(req_addr[1]))
    else $error("shared pin two not address bit one");
  a_boot_ref: assert property (req_valid && req_ready && bad |=> boot_fault && chip_sel_n[0])
    else $error("byte write boot access not refused");
endmodule // smrb_read_chk
bind smrb_read_ctrl smrb_read_chk smrb_read_chk_i (.*);
`default_nettype wire

// ### sim/smrb_mem_model.sv
// behavioural static memory answering reads
`default_nettype none
module smrb_mem_model (
  input  wire logic        clk,
  input  wire logic [25:0] mem_addr,
  input  wire logic [5:0]  chip_sel_n,
  input  wire logic        rd_strobe_n,
  output var  logic [31:0] mem_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last = 32'h0;
  // data only while selected and read low; released bus shows inverse so stale data fails
  wire logic drive = !(&chip_sel_n) && !rd_strobe_n;
  always @(posedge clk) if (drive) last <= {6'h15, mem_addr};
  assign mem_data_in = drive ? {6'h15, mem_addr} : ~last;
endmodule // smrb_mem_model
`default_nettype wire

// ### sim/tb_smrb_read_ctrl.sv
// testbench for the static memory read controller
`default_nettype none
module tb_smrb_read_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, req_valid, req_ready, rd_done, boot_fault;
  logic rd_strobe_n, wr_enable_n, pin0_n, byte_wr1_n, pin2_n, pin3_n;
  logic [2:0] req_cs;
  logic [3:0] req_lanes;
  logic [25:0] req_addr, mem_addr;
  logic [31:0] rd_data, mem_data_in;
  logic [11:0] cfg_bus_width;
  logic [5:0] cfg_access_type, cfg_read_mode, chip_sel_n;
  logic [53:0] cfg_rd_setup, cfg_rd_pulse, cfg_cs_setup, cfg_cs_pulse, cfg_cycle_total;
  int n_mismatch = 0;
  int n_tests = 0;
  smrb_read_ctrl smrb_read_ctrl_i (.clk, .rst_n, .req_valid, .req_cs, .req_addr, .req_lanes, .req_ready,
    .rd_done, .rd_data, .boot_fault, .cfg_bus_width, .cfg_access_type, .cfg_read_mode, .cfg_rd_setup,
    .cfg_rd_pulse, .cfg_cs_setup, .cfg_cs_pulse, .cfg_cycle_total, .mem_addr, .chip_sel_n, .rd_strobe_n,
    .wr_enable_n, .pin0_n, .byte_wr1_n, .pin2_n, .pin3_n, .mem_data_in);
  smrb_mem_model smrb_mem_model_i (.clk, .mem_addr, .chip_sel_n, .rd_strobe_n, .mem_data_in);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----
  // shared tasks
  // ----
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(input int c, input logic [1:0] w, input logic t, m, input logic [8:0] rs, rp, cs, cp, tt);
    @(posedge clk);
    cfg_bus_width[c*2 +: 2] <= w;
    cfg_access_type[c] <= t;
    cfg_read_mode[c] <= m;
    cfg_rd_setup[c*9 +: 9] <= rs;
    cfg_rd_pulse[c*9 +: 9] <= rp;
    cfg_cs_setup[c*9 +: 9] <= cs;
    cfg_cs_pulse[c*9 +: 9] <= cp;
    cfg_cycle_total[c*9 +: 9] <= tt;
  endtask
  // one read; outputs sampled mid-cycle so edge updates have landed
  task automatic rd(input logic [2:0] c, input logic [25:0] a, input logic [3:0] l, input int lat, rl, cl,
                    input logic [31:0] d, input logic [3:0] p, m, input int bf, rdy);
    int n, nr, nc, nb, nw, seen;
    logic [31:0] got;
    logic [3:0] pv;
    nr = 0; nc = 0; nb = 0; nw = 0; seen = 0; got = 32'h0; pv = 4'h0;
    @(posedge clk);
    req_cs <= c; req_addr <= a; req_lanes <= l; req_valid <= 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 1; n < 12; n++) begin
      @(negedge clk);
      nr += (rd_strobe_n === 1'b0);
      nc += (chip_sel_n[c] === 1'b0);
      nb += (boot_fault === 1'b1);
      nw += (req_ready === 1'b0);
      if (n == 1) pv = {pin3_n, pin2_n, byte_wr1_n, pin0_n};
      if (rd_done === 1'b1 && seen == 0) begin seen = n; got = rd_data; end
    end
    cmp("latency", lat, seen - 1);
    cmp("read low", rl, nr);
    cmp("select low", cl, nc);
    cmp("boot fault", bf, nb);
    cmp("pins", p & m, pv & m);
    if (seen != 0) cmp("data", d, got);
    if (rdy >= 0) cmp("busy", rdy, nw);
  endtask
  // ----
  // scenarios; every pulse programmed at least one cycle
  // ----
  task automatic t_word32;
    cfg(1, 2'h2, 1'h0, 1'h1, 9'h2, 9'h3, 9'h1, 9'h5, 9'h8);
    rd(1, 26'h3FFFFFF, 4'hF, 5, 3, 5, 32'h57FFFFFC, 4'h0, 4'hF, 0, 7);
  endtask
  task automatic t_byte8;
    cfg(2, 2'h0, 1'h0, 1'h0, 9'h1, 9'h4, 9'h2, 9'h1, 9'h6);
    rd(2, 26'h0000003, 4'h1, 3, 4, 1, 32'h54000003, 4'h5, 4'h5, 0, 5);
  endtask
  task automatic t_half16;
    cfg(3, 2'h1, 1'h1, 1'h1, 9'h0, 9'h4, 9'h0, 9'h4, 9'h4);
    rd(3, 26'h0000007, 4'h3, 4, 4, 4, 32'h54000006, 4'h7, 4'h7, 0, 3);
  endtask
  // two reads on one chip select with null setup and hold, request held through the busy span
  task automatic t_back2back;
    int n, nr, nc, nd;
    logic [31:0] got;
    nr = 0;
    nc = 0;
    nd = 0;
    got = 32'h0;
    @(posedge clk);
    req_cs <= 3'h3;
    req_addr <= 26'h0000010;
    req_lanes <= 4'h3;
    req_valid <= 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    for (n = 1; n < 12; n++) begin
      @(posedge clk);
      if (n == 5) req_valid <= 1'b0;
      @(negedge clk);
      nr += (rd_strobe_n === 1'b0);
      nc += (chip_sel_n[3] === 1'b0);
      nd += (rd_done === 1'b1);
      if (rd_done === 1'b1) got = rd_data;
    end
    cmp("b2b read low", 8, nr);
    cmp("b2b select low", 8, nc);
    cmp("b2b reads", 2, nd);
    cmp("b2b data", 32'h54000010, got);
  endtask
  task automatic t_sel16;
    cfg(4, 2'h1, 1'h0, 1'h1, 9'h1, 9'h1, 9'h0, 9'h3, 9'h3);
    rd(4, 26'h0000001, 4'h2, 2, 1, 3, 32'h54000000, 4'h1, 4'h7, 0, 2);
  endtask
  task automatic t_boot;
    cfg(0, 2'h1, 1'h1, 1'h1, 9'h1, 9'h2, 9'h0, 9'h3, 9'h4);
    rd(0, 26'h0000010, 4'h3, -1, 0, 0, 32'h0, 4'h0, 4'h0, 1, -1);
    cfg(5, 2'h2, 1'h1, 1'h1, 9'h1, 9'h2, 9'h0, 9'h3, 9'h4);
    rd(5, 26'h0000022, 4'hF, 3, 2, 3, 32'h54000020, 4'hF, 4'hF, 0, 3);
  endtask
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence: reset held 20 cycles, then the scenarios
  initial begin
    rst_n = 1'b0; req_valid = 1'b0; req_cs = 3'h0; req_addr = 26'h0; req_lanes = 4'h0;
    cfg_bus_width = 12'h0; cfg_access_type = 6'h0; cfg_read_mode = 6'h0;
    cfg_rd_setup = 54'h0; cfg_rd_pulse = 54'h0; cfg_cs_setup = 54'h0;
    cfg_cs_pulse = 54'h0; cfg_cycle_total = 54'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_word32;
    t_byte8;
    t_half16;
    t_back2back;
    t_sel16;
    t_boot;
    complete_run;
  end
  // watchdog well past the hundred-odd cycles the scenarios need
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule // tb_smrb_read_ctrl
`default_nettype wire
